/* core/emtg_params.svh */
`ifndef EMTG_PARAMS_SVH
`define EMTG_PARAMS_SVH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define EMTG_ADDR_W 8
`define EMTG_DATA_W 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EMTG_OFS_TRIG_UPPER 8'h48
`define EMTG_OFS_PAIR_A_MASK 8'h49
`define EMTG_OFS_PAIR_B_MASK 8'h4A
`define EMTG_OFS_VMON_MASK 8'h4E
`define EMTG_OFS_PAIR_A_STAT 8'h60
`define EMTG_OFS_PAIR_B_STAT 8'h61
`define EMTG_OFS_VMON_STAT 8'h62

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define EMTG_READ_ZERO 8'h00
`define EMTG_STAT_RESET 24'h00_0000

// ----------------------------------------------------------------
// trigger gate fields
// ----------------------------------------------------------------
`define EMTG_BIT_P9_GATE 0
`define EMTG_BIT_P9_LEVEL 1
`define EMTG_BIT_P10_GATE 2
`define EMTG_BIT_P10_LEVEL 3

// ----------------------------------------------------------------
// regulator pair fields, upper regulator sits EMTG_HI_SHIFT higher
// ----------------------------------------------------------------
`define EMTG_BIT_OV 0
`define EMTG_BIT_UV 1
`define EMTG_BIT_RSV 2
`define EMTG_BIT_OC 3
`define EMTG_HI_SHIFT 4

// ----------------------------------------------------------------
// monitor fields
// ----------------------------------------------------------------
`define EMTG_BIT_VS_OV 0
`define EMTG_BIT_VS_UV 1
`define EMTG_BIT_M1_OV 2
`define EMTG_BIT_M1_UV 3
`define EMTG_BIT_RSV_LO 4
`define EMTG_BIT_M2_OV 5
`define EMTG_BIT_M2_UV 6
`define EMTG_BIT_RSV_HI 7

// ----------------------------------------------------------------
// source counts and bank slices
// ----------------------------------------------------------------
`define EMTG_NUM_REGS 4
`define EMTG_NUM_MONS 3
`define EMTG_NUM_SRC 20
`define EMTG_STAT_W 24
`define EMTG_SLICE_B 8
`define EMTG_SLICE_V 16

`endif

/* core/emtg_pkg.sv */
package emtg_pkg;
  typedef logic [7:0] emtg_byte_t;
  typedef logic [7:0] emtg_addr_t;
endpackage

/* core/emtg_sync.sv */
module emtg_sync #(
  parameter int WIDTH = 20
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ----------------------------------------------------------------
  // two-stage synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
          meta <= 1'b0;
          sync_out[i] <= 1'b0;
        end else if (ce_in) begin
          meta <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate
endmodule

/* core/emtg_irq_bank.sv */
module emtg_irq_bank #(
  parameter int WIDTH = 24
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] level_in,
  input wire logic [WIDTH-1:0] gate_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] event_out,
  output logic [WIDTH-1:0] status_out
);
  // ----------------------------------------------------------------
  // rising-edge detect and sticky status
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] prev;
  wire [WIDTH-1:0] set_bits;
  wire [WIDTH-1:0] next_status;

  assign event_out = level_in & ~prev;
  // a gated source never reaches status, so unmasking later does not fire it
  assign set_bits = event_out & ~gate_in;
  // set beats a simultaneous write-one-to-clear
  assign next_status = (status_out & ~clear_in) | set_bits;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      prev <= '0;
      status_out <= '0;
    end else if (ce_in) begin
      prev <= level_in;
      status_out <= next_status;
    end
  end
endmodule

/* core/emtg_top.sv */
// How it works
// - gate bit 1 blocks pin nine/ten level from trigger path; 0 passes it.
// - a gated pin presents its force-level bit to the state machine instead.
// - trigger register: bit3 ten level, bit2 ten gate, bit1/0 nine; 7:4 reserved.
// - overcurrent gate bit 1 stops that regulator's overcurrent interrupt.
// - undervoltage gate bit 1 stops that regulator's undervoltage interrupt.
// - overvoltage gate bit 1 stops that regulator's overvoltage interrupt.
// - pair A register: reg one on bits 0,1,3; reg two on 4,5,7.
// - pair B register: reg three on bits 0,1,3; reg four on 4,5,7.
// - reset loads every gate and level bit from nonvolatile defaults.
// - monitor register: supply bits 0,1; monitor one 2,3; monitor two 5,6.
`include "emtg_params.svh"

module emtg_top #(
  parameter int ADDR_W = `EMTG_ADDR_W,
  parameter int DATA_W = `EMTG_DATA_W,
  parameter int NUM_REGS = `EMTG_NUM_REGS,
  parameter int NUM_MONS = `EMTG_NUM_MONS
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [DATA_W-1:0] rd_data_out,
  input wire logic [DATA_W-1:0] nvm_trig_upper_in,
  input wire logic [DATA_W-1:0] nvm_pair_a_in,
  input wire logic [DATA_W-1:0] nvm_pair_b_in,
  input wire logic [DATA_W-1:0] nvm_vmon_in,
  input wire logic pin_nine_in,
  input wire logic pin_ten_in,
  input wire logic [NUM_REGS-1:0] reg_overvolt_in,
  input wire logic [NUM_REGS-1:0] reg_undervolt_in,
  input wire logic [NUM_REGS-1:0] reg_overcurrent_in,
  input wire logic [NUM_MONS-1:0] mon_overvolt_in,
  input wire logic [NUM_MONS-1:0] mon_undervolt_in,
  output logic pin_nine_trigger_out,
  output logic pin_ten_trigger_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  emtg_pkg::emtg_byte_t pin_trigger_gate_upper;
  emtg_pkg::emtg_byte_t regulator_pair_a_irq_mask;
  emtg_pkg::emtg_byte_t regulator_pair_b_irq_mask;
  emtg_pkg::emtg_byte_t voltage_monitor_irq_mask;

  // ----------------------------------------------------------------
  // synchronised sources
  // ----------------------------------------------------------------
  wire [`EMTG_NUM_SRC-1:0] src_raw;
  wire [`EMTG_NUM_SRC-1:0] src_sync;
  wire [NUM_REGS-1:0] ov_s;
  wire [NUM_REGS-1:0] uv_s;
  wire [NUM_REGS-1:0] oc_s;
  wire [NUM_MONS-1:0] mov_s;
  wire [NUM_MONS-1:0] muv_s;
  wire pin_nine_s;
  wire pin_ten_s;

  assign src_raw = {pin_ten_in, pin_nine_in, mon_undervolt_in, mon_overvolt_in,
                    reg_overcurrent_in, reg_undervolt_in, reg_overvolt_in};
  assign {pin_ten_s, pin_nine_s, muv_s, mov_s, oc_s, uv_s, ov_s} = src_sync;

  emtg_sync #(
    .WIDTH(`EMTG_NUM_SRC)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .async_in(src_raw),
    .sync_out(src_sync)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_go;
  wire rd_go;
  wire hit_trig;
  wire hit_pair_a;
  wire hit_pair_b;
  wire hit_vmon;
  wire hit_stat_a;
  wire hit_stat_b;
  wire hit_stat_v;

  assign wr_go = wr_strobe_in & ce_in;
  assign rd_go = rd_strobe_in & ce_in;
  assign hit_trig = (addr_in == `EMTG_OFS_TRIG_UPPER);
  assign hit_pair_a = (addr_in == `EMTG_OFS_PAIR_A_MASK);
  assign hit_pair_b = (addr_in == `EMTG_OFS_PAIR_B_MASK);
  assign hit_vmon = (addr_in == `EMTG_OFS_VMON_MASK);
  assign hit_stat_a = (addr_in == `EMTG_OFS_PAIR_A_STAT);
  assign hit_stat_b = (addr_in == `EMTG_OFS_PAIR_B_STAT);
  assign hit_stat_v = (addr_in == `EMTG_OFS_VMON_STAT);

  // ----------------------------------------------------------------
  // mask and trigger-gate registers
  // ----------------------------------------------------------------
  // defaults come from the nonvolatile store, never from a constant
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_trigger_gate_upper <= nvm_trig_upper_in;
      regulator_pair_a_irq_mask <= nvm_pair_a_in;
      regulator_pair_b_irq_mask <= nvm_pair_b_in;
      voltage_monitor_irq_mask <= nvm_vmon_in;
    end else if (wr_go) begin
      if (hit_trig) begin
        pin_trigger_gate_upper <= wr_data_in;
      end
      if (hit_pair_a) begin
        regulator_pair_a_irq_mask <= wr_data_in;
      end
      if (hit_pair_b) begin
        regulator_pair_b_irq_mask <= wr_data_in;
      end
      if (hit_vmon) begin
        voltage_monitor_irq_mask <= wr_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger gating toward the state machine
  // ----------------------------------------------------------------
  wire pin_nine_trigger_gate;
  wire pin_nine_trigger_force_level;
  wire pin_ten_trigger_gate;
  wire pin_ten_trigger_force_level;
  wire next_trig_nine;
  wire next_trig_ten;

  assign pin_nine_trigger_gate = pin_trigger_gate_upper[`EMTG_BIT_P9_GATE];
  assign pin_nine_trigger_force_level = pin_trigger_gate_upper[`EMTG_BIT_P9_LEVEL];
  assign pin_ten_trigger_gate = pin_trigger_gate_upper[`EMTG_BIT_P10_GATE];
  assign pin_ten_trigger_force_level = pin_trigger_gate_upper[`EMTG_BIT_P10_LEVEL];
  assign next_trig_nine = pin_nine_trigger_gate ?
                          pin_nine_trigger_force_level : pin_nine_s;
  assign next_trig_ten = pin_ten_trigger_gate ?
                         pin_ten_trigger_force_level : pin_ten_s;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_nine_trigger_out <= 1'b0;
      pin_ten_trigger_out <= 1'b0;
    end else if (ce_in) begin
      pin_nine_trigger_out <= next_trig_nine;
      pin_ten_trigger_out <= next_trig_ten;
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources laid out as the mask registers
  // ----------------------------------------------------------------
  wire [2*DATA_W-1:0] ev_regs;
  wire [DATA_W-1:0] ev_vmon;

  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_reg
      // pair index r/2, regulator within the pair r%2
      localparam int BASE = (r / 2) * DATA_W + (r % 2) * `EMTG_HI_SHIFT;
      assign ev_regs[BASE + `EMTG_BIT_OV] = ov_s[r];
      assign ev_regs[BASE + `EMTG_BIT_UV] = uv_s[r];
      assign ev_regs[BASE + `EMTG_BIT_RSV] = 1'b0;
      assign ev_regs[BASE + `EMTG_BIT_OC] = oc_s[r];
    end
  endgenerate

  assign ev_vmon[`EMTG_BIT_VS_OV] = mov_s[0];
  assign ev_vmon[`EMTG_BIT_VS_UV] = muv_s[0];
  assign ev_vmon[`EMTG_BIT_M1_OV] = mov_s[1];
  assign ev_vmon[`EMTG_BIT_M1_UV] = muv_s[1];
  assign ev_vmon[`EMTG_BIT_RSV_LO] = 1'b0;
  assign ev_vmon[`EMTG_BIT_M2_OV] = mov_s[2];
  assign ev_vmon[`EMTG_BIT_M2_UV] = muv_s[2];
  assign ev_vmon[`EMTG_BIT_RSV_HI] = 1'b0;

  // ----------------------------------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------------------------------
  wire [`EMTG_STAT_W-1:0] bank_level;
  wire [`EMTG_STAT_W-1:0] bank_gate;
  wire [`EMTG_STAT_W-1:0] bank_clear;
  wire [`EMTG_STAT_W-1:0] ev_rise;
  wire [`EMTG_STAT_W-1:0] status;
  wire [DATA_W-1:0] clr_a;
  wire [DATA_W-1:0] clr_b;
  wire [DATA_W-1:0] clr_v;
  wire [DATA_W-1:0] stat_a;
  wire [DATA_W-1:0] stat_b;
  wire [DATA_W-1:0] stat_v;
  wire [`EMTG_STAT_W-1:0] pending;

  assign clr_a = (wr_go && hit_stat_a) ? wr_data_in : `EMTG_READ_ZERO;
  assign clr_b = (wr_go && hit_stat_b) ? wr_data_in : `EMTG_READ_ZERO;
  assign clr_v = (wr_go && hit_stat_v) ? wr_data_in : `EMTG_READ_ZERO;
  assign bank_level = {ev_vmon, ev_regs};
  assign bank_gate = {voltage_monitor_irq_mask, regulator_pair_b_irq_mask,
                      regulator_pair_a_irq_mask};
  assign bank_clear = {clr_v, clr_b, clr_a};
  assign {stat_v, stat_b, stat_a} = status;

  emtg_irq_bank #(
    .WIDTH(`EMTG_STAT_W)
  ) u_bank (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .level_in(bank_level),
    .gate_in(bank_gate),
    .clear_in(bank_clear),
    .event_out(ev_rise),
    .status_out(status)
  );

  // masking again here keeps a bit set before a later mask write quiet
  assign pending = status & ~bank_gate;
  assign irq_out = |pending;

  // ----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] rd_mux;

  assign rd_mux = hit_trig ? pin_trigger_gate_upper :
                  hit_pair_a ? regulator_pair_a_irq_mask :
                  hit_pair_b ? regulator_pair_b_irq_mask :
                  hit_vmon ? voltage_monitor_irq_mask :
                  hit_stat_a ? stat_a :
                  hit_stat_b ? stat_b :
                  hit_stat_v ? stat_v : `EMTG_READ_ZERO;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rd_data_out <= `EMTG_READ_ZERO;
    end else if (rd_go) begin
      rd_data_out <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  localparam int OC_ONE = `EMTG_BIT_OC;
  localparam int UV_TWO = `EMTG_BIT_UV + `EMTG_HI_SHIFT;
  localparam int OV_THREE = `EMTG_SLICE_B + `EMTG_BIT_OV;
  localparam int UV_THREE = `EMTG_SLICE_B + `EMTG_BIT_UV;
  localparam int M2_UV = `EMTG_SLICE_V + `EMTG_BIT_M2_UV;
  localparam int M1_OV = `EMTG_SLICE_V + `EMTG_BIT_M1_OV;

  sequence s_unmasked_fire;
    ce_in && ev_rise[UV_THREE] && !regulator_pair_b_irq_mask[`EMTG_BIT_UV];
  endsequence

  sequence s_irq_seen;
    status[UV_THREE] && irq_out;
  endsequence

  a_pin_pass_through: assert property (
    $past(resetn_in) && $past(ce_in) && !$past(pin_nine_trigger_gate)
      |-> pin_nine_trigger_out == $past(pin_nine_s))
    else $error("pin nine not passed while ungated");

  a_pin_force_level: assert property (
    $past(resetn_in) && $past(ce_in) && $past(pin_ten_trigger_gate)
      |-> pin_ten_trigger_out == $past(pin_ten_trigger_force_level))
    else $error("pin ten not forced to level while gated");

  a_pin_ten_pass: assert property (
    $past(resetn_in) && $past(ce_in) && !$past(pin_ten_trigger_gate)
      |-> pin_ten_trigger_out == $past(pin_ten_s))
    else $error("pin ten not passed while ungated");

  a_pin_nine_force: assert property (
    $past(resetn_in) && $past(ce_in) && $past(pin_nine_trigger_gate)
      |-> pin_nine_trigger_out == $past(pin_nine_trigger_force_level))
    else $error("pin nine not forced to level while gated");

  a_trig_field_map: assert property (
    wr_go && hit_trig |=> pin_ten_trigger_gate == $past(wr_data_in[`EMTG_BIT_P10_GATE])
      && pin_nine_trigger_force_level == $past(wr_data_in[`EMTG_BIT_P9_LEVEL]))
    else $error("trigger field landed in wrong bit");

  a_oc_suppressed: assert property (
    ce_in && ev_rise[OC_ONE] && regulator_pair_a_irq_mask[`EMTG_BIT_OC] && !status[OC_ONE]
      |=> !status[OC_ONE])
    else $error("gated overcurrent still flagged");

  a_oc_raised: assert property (
    ce_in && $rose(oc_s[0]) && !regulator_pair_a_irq_mask[OC_ONE] |=> status[OC_ONE])
    else $error("ungated overcurrent not flagged");

  a_uv_raised: assert property (
    s_unmasked_fire |=> s_irq_seen)
    else $error("ungated undervoltage not raised");

  a_ov_raised: assert property (
    ce_in && ev_rise[OV_THREE] && !regulator_pair_b_irq_mask[`EMTG_BIT_OV]
      |=> status[OV_THREE] ##1 status[OV_THREE] || $past(clr_b[`EMTG_BIT_OV]))
    else $error("ungated overvoltage not raised");

  a_pair_a_layout: assert property (
    ce_in && $rose(uv_s[1]) && !regulator_pair_a_irq_mask[UV_TWO] |=> status[UV_TWO])
    else $error("reg two undervolt not on bit 5");

  a_pair_b_readback: assert property (
    rd_go && hit_pair_b |=> rd_data_out == $past(regulator_pair_b_irq_mask))
    else $error("pair B read data wrong");

  a_reset_from_nvm: assert property (
    $rose(resetn_in) |-> regulator_pair_a_irq_mask == $past(nvm_pair_a_in)
      && pin_trigger_gate_upper == $past(nvm_trig_upper_in))
    else $error("mask not loaded from nonvolatile default");

  a_vmon_suppressed: assert property (
    ce_in && ev_rise[M2_UV] && voltage_monitor_irq_mask[`EMTG_BIT_M2_UV] && !status[M2_UV]
      |=> !status[M2_UV])
    else $error("gated monitor two undervolt flagged");

  a_m1_ov_raised: assert property (
    ce_in && $rose(mov_s[1]) && !voltage_monitor_irq_mask[`EMTG_BIT_M1_OV] |=> status[M1_OV])
    else $error("ungated monitor one overvolt not flagged");

  a_irq_drops_clear: assert property (
    irq_out && wr_go && hit_stat_b && (pending == {DATA_W'(0), stat_b, DATA_W'(0)})
      && (wr_data_in == stat_b) && !(|ev_rise) |=> !irq_out)
    else $error("interrupt stays after clearing all");

  // a dropped enable must hold every register, masks and status alike
  a_ce_freeze: assert property (
    !ce_in |=> $stable(status) && $stable(regulator_pair_a_irq_mask) && $stable(rd_data_out)
      && $stable(pin_ten_trigger_out))
    else $error("state moved while clock enable low");
endmodule

/* dv/emtg_host_model.sv */
// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module emtg_host_model (
  input wire logic clk_sys_in,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out,
  output logic wr_strobe_out,
  output logic rd_strobe_out,
  input wire logic [7:0] rd_data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr_out = 8'h00;
    wr_data_out = 8'h00;
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
  end

  // released lines show the inverse so stale values cannot pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_strobe_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_strobe_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_strobe_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_strobe_out <= 1'b0;
    addr_out <= ~a;
    // data hold until the next read strobe: take them at the edge after they load
    @(posedge clk_sys_in);
    d = rd_data_in;
  endtask
endmodule

/* dv/testbench.sv */
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys_in;
  logic resetn_in;
  logic ce_in;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  logic [7:0] nv_t, nv_a, nv_b, nv_v;
  logic pin_nine, pin_ten, trig_nine, trig_ten, irq;
  logic [3:0] ov, uv, oc;
  logic [2:0] mov, muv;
  logic [31:0] seed;
  int miscompares;
  int checked;

  emtg_top emtg_top_inst (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd),
    .rd_data_out(rdata), .nvm_trig_upper_in(nv_t), .nvm_pair_a_in(nv_a),
    .nvm_pair_b_in(nv_b), .nvm_vmon_in(nv_v), .pin_nine_in(pin_nine),
    .pin_ten_in(pin_ten), .reg_overvolt_in(ov), .reg_undervolt_in(uv),
    .reg_overcurrent_in(oc), .mon_overvolt_in(mov), .mon_undervolt_in(muv),
    .pin_nine_trigger_out(trig_nine), .pin_ten_trigger_out(trig_ten), .irq_out(irq)
  );

  emtg_host_model emtg_host_model_inst (
    .clk_sys_in(clk_sys_in), .addr_out(addr), .wr_data_out(wdata),
    .wr_strobe_out(wr), .rd_strobe_out(rd), .rd_data_in(rdata)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rb();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0000_0000);
    return seed[7:0];
  endfunction

  function automatic logic exp_trig(input logic [7:0] v, input logic pin, input int n);
    return v[2*n] ? v[2*n+1] : pin;
  endfunction

  function automatic logic [7:0] mask_addr(input int i);
    case (i)
      0: return 8'h48;
      1: return 8'h49;
      2: return 8'h4A;
      default: return 8'h4E;
    endcase
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    emtg_host_model_inst.write_reg(a, v);
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    emtg_host_model_inst.read_reg(a, v);
  endtask

  task automatic test_done;
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // nvm ports change after release: only the reset-time value may stick
  task automatic do_reset;
    logic [7:0] e [4];
    @(posedge clk_sys_in);
    e = '{rb(), rb(), rb(), rb()};
    resetn_in <= 1'b0;
    {nv_t, nv_a, nv_b, nv_v} <= {e[0], e[1], e[2], e[3]};
    cyc(8);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    {nv_t, nv_a, nv_b, nv_v} <= {~e[0], ~e[1], ~e[2], ~e[3]};
    for (int i = 0; i < 4; i++) begin
      rreg(mask_addr(i), d);
      `CHK(d, e[i])
      rreg(8'h60 + i[7:0], d);
      if (i < 3) `CHK(d, 8'h00)
    end
    `CHK(irq, 1'b0)
  endtask

  task automatic set_src(input int t, input int i, input logic v);
    @(posedge clk_sys_in);
    case (t)
      0: ov[i] <= v;
      1: uv[i] <= v;
      2: oc[i] <= v;
      3: mov[i] <= v;
      default: muv[i] <= v;
    endcase
  endtask

  // t: 0 overvolt, 1 undervolt, 2 overcurrent, 3/4 monitor over/under
  task automatic run_src(input int t, input int i);
    logic [7:0] sa, ma, m;
    int b;
    sa = (t > 2) ? 8'h62 : ((i < 2) ? 8'h60 : 8'h61);
    ma = (t > 2) ? 8'h4E : ((i < 2) ? 8'h49 : 8'h4A);
    b = (t > 2) ? ((i == 0) ? 0 : (i == 1) ? 2 : 5) + t - 3 : (i % 2) * 4 + ((t == 2) ? 3 : t);
    m = 8'h01 << b;
    wreg(ma, ~m);
    set_src(t, i, 1'b1);
    cyc(4);
    rreg(sa, d);
    `CHK(d, m)
    `CHK(irq, 1'b1)
    // mask and status flops move at the write edge: look one edge later
    wreg(ma, 8'hFF);
    cyc(1);
    `CHK(irq, 1'b0)
    wreg(ma, ~m);
    cyc(1);
    `CHK(irq, 1'b1)
    wreg(sa, m);
    cyc(1);
    `CHK(irq, 1'b0)
    set_src(t, i, 1'b0);
    cyc(3);
    wreg(ma, 8'hFF);
    set_src(t, i, 1'b1);
    cyc(4);
    rreg(sa, d);
    `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    set_src(t, i, 1'b0);
    cyc(3);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    cyc(100000);
    miscompares++;
    test_done();
  end

  initial begin
    logic [7:0] v [4];
    seed = 32'h0000_02A8;
    miscompares = 0;
    checked = 0;
    resetn_in = 1'b0;
    ce_in = 1'b1;
    {nv_t, nv_a, nv_b, nv_v} = 32'h0000_0000;
    {pin_nine, pin_ten} = 2'b00;
    {ov, uv, oc, mov, muv} = 18'h0_0000;
    do_reset();
    // back-to-back writes then reads, reserved bits included
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 4; i++) begin
        v[i] = rb();
        wreg(mask_addr(i), v[i]);
      end
      for (int i = 0; i < 4; i++) begin
        rreg(mask_addr(i), d);
        `CHK(d, v[i])
      end
    end
    wreg(8'h4C, 8'hA5);
    rreg(8'h4C, d);
    `CHK(d, 8'h00)
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    wreg(8'h49, ~v[1]);
    ce_in <= 1'b1;
    rreg(8'h49, d);
    `CHK(d, v[1])
    // every gate and level combination with random pin levels
    for (int k = 0; k < 16; k++) begin
      v[0] = {rb() & 8'hF0} | k[7:0];
      wreg(8'h48, v[0]);
      repeat (3) begin
        d = rb();
        @(posedge clk_sys_in);
        pin_nine <= d[0];
        pin_ten <= d[1];
        cyc(4);
        #1;
        `CHK(trig_nine, exp_trig(v[0], d[0], 0))
        `CHK(trig_ten, exp_trig(v[0], d[1], 1))
      end
    end
    for (int i = 0; i < 4; i++) begin
      wreg(mask_addr(i), 8'hFF);
    end
    for (int t = 0; t < 5; t++) begin
      for (int i = 0; i < ((t > 2) ? 3 : 4); i++) begin
        run_src(t, i);
      end
    end
    do_reset();
    test_done();
  end
endmodule
